// ==== ewdt_pkg.sv ====
// Purpose: Shared constants for the watchdog device and its core-side end
// Assumes: Control register is eight bits wide
// Notes: Core-side register offsets are word indices on the software port
package ewdt_pkg;
  // Control register bit positions
  localparam int CTL_W = 8;
  localparam int BIT_IRQ_FLAG = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_TSEL_HI = 5;
  localparam int BIT_CHG_EN = 4;
  localparam int BIT_RST_EN = 3;
  localparam int BIT_TSEL_LO_TOP = 2;
  // Reset-cause register bit of the watchdog reset flag
  localparam int BIT_WD_RFLAG = 3;

  // Time-out selection
  localparam int TSEL_W = 4;
  localparam logic [TSEL_W-1:0] TSEL_RESET = 4'h0;
  localparam logic [TSEL_W-1:0] TSEL_MAX = 4'h9;
  localparam int BASE_SHIFT = 11;
  localparam int CNT_W = 20;

  // Unlock window length in system clock cycles
  localparam int UNLOCK_CYCLES = 4;
  localparam int WIN_W = 3;

  // Clock rates
  localparam int SYS_CLK_HZ = 50000000;
  localparam int OSC_CLK_HZ = 128000;

  // Core-side software port map
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CAUSE = 4'h1;
  localparam logic [ADDR_W-1:0] REG_RESTART = 4'h2;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h3;
  localparam int STAT_IRQ = 0;
  localparam int STAT_WAKE = 1;
  localparam int STAT_WIN = 2;
endpackage : ewdt_pkg

// ==== ewdt_if.sv ====
// Purpose: Link between the watchdog device and the processor core end
// Assumes: Both ends run on the same mclk
// Notes: All pulses are one mclk cycle long
`timescale 1ns/1ps
`default_nettype none
interface ewdt_if;
  import ewdt_pkg::*;
  logic ctl_wr;
  logic [CTL_W-1:0] ctl_wdata;
  logic [CTL_W-1:0] ctl_rdata;
  logic restart;
  logic rflag_clr;
  logic rflag;
  logic irq_req;
  logic irq_ack;
  logic wake;
  logic sys_reset;

  modport dev (
    input ctl_wr, ctl_wdata, restart, rflag_clr, irq_ack,
    output ctl_rdata, rflag, irq_req, wake, sys_reset
  );
  modport core (
    output ctl_wr, ctl_wdata, restart, rflag_clr, irq_ack,
    input ctl_rdata, rflag, irq_req, wake, sys_reset
  );
endinterface : ewdt_if
`default_nettype wire

// ==== ewdt_device.sv ====
// Purpose: Watchdog counter with interrupt, reset and combined modes
// Assumes: osc_pin is a free-running low-frequency oscillator, async to mclk
// Notes: reset acts as power-on reset; the watchdog reset flag survives
//   the system reset this block issues
`timescale 1ns/1ps
`default_nettype none
module ewdt_device
  import ewdt_pkg::*;
#(
  parameter int CNT_WIDTH = CNT_W
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic osc_pin,
  input wire logic always_on_fuse,
  ewdt_if.dev link
);

  // Top code wraps to all ones, so BASE_SHIFT plus TSEL_MAX bits suffice
  if (CNT_WIDTH < BASE_SHIFT + int'(TSEL_MAX)) begin : g_chk_w
    $error("ewdt_device: CNT_WIDTH too small for longest time-out");
  end
  if (2 * OSC_CLK_HZ >= SYS_CLK_HZ) begin : g_chk_clk
    $error("ewdt_device: oscillator too fast to sample on mclk");
  end

  // Terminal count for a time-out code; reserved codes act as the longest
  function automatic logic [CNT_WIDTH-1:0] timeout_limit(
    input logic [TSEL_W-1:0] sel
  );
    logic [TSEL_W-1:0] s;
    logic [CNT_WIDTH-1:0] one;
    s = (sel > TSEL_MAX) ? TSEL_MAX : sel;
    one = {{(CNT_WIDTH-1){1'b0}}, 1'b1};
    timeout_limit = (one << (BASE_SHIFT + int'(s))) - one;
  endfunction : timeout_limit

  logic osc_meta_ff;
  logic osc_sync_ff;
  logic osc_prev_ff;
  logic fuse_meta_ff;
  logic fuse_ff;
  logic [CNT_WIDTH-1:0] cnt_ff;
  logic [TSEL_W-1:0] tsel_ff;
  logic [WIN_W-1:0] win_ff;
  logic re_ff;
  logic ie_ff;
  logic irq_flag_ff;
  logic rflag_ff;
  logic sys_reset_ff;

  logic tick;
  logic eff_re;
  logic eff_ie;
  logic running;
  logic expire;
  logic win_open;
  logic unlock_wr;
  logic change_wr;
  logic [CTL_W-1:0] d;

  // Oscillator and fuse strap cross in through two flops each
  always_ff @(posedge mclk) begin
    if (reset) begin
      osc_meta_ff <= 1'b0;
      osc_sync_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
    end else begin
      osc_meta_ff <= osc_pin;
      osc_sync_ff <= osc_meta_ff;
      osc_prev_ff <= osc_sync_ff;
    end
  end

  // Fuse sampled after release, so a strap never feeds the reset value
  always_ff @(posedge mclk) begin
    if (reset) begin
      fuse_meta_ff <= 1'b0;
      fuse_ff <= 1'b0;
    end else begin
      fuse_meta_ff <= always_on_fuse;
      fuse_ff <= fuse_meta_ff;
    end
  end

  assign tick = osc_sync_ff & ~osc_prev_ff;
  assign d = link.ctl_wdata;

  // Fuse overrides both stored enables; reset flag forces reset enable only
  assign eff_re = fuse_ff | re_ff | rflag_ff;
  assign eff_ie = ~fuse_ff & ie_ff;
  assign running = eff_re | eff_ie;
  assign expire = tick & running & (cnt_ff == timeout_limit(tsel_ff));

  assign win_open = (win_ff != '0);
  assign unlock_wr = link.ctl_wr & d[BIT_CHG_EN] & d[BIT_RST_EN];
  assign change_wr = link.ctl_wr & win_open & ~d[BIT_CHG_EN];

  // Watchdog counter; restart has priority over counting
  always_ff @(posedge mclk) begin
    if (reset || sys_reset_ff || link.restart) begin
      cnt_ff <= '0;
    end else if (tick && running) begin
      if (expire) begin
        cnt_ff <= '0;
      end else begin
        cnt_ff <= cnt_ff + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // Reset issue: reset-only mode, or combined mode with flag still pending
  always_ff @(posedge mclk) begin
    if (reset) begin
      sys_reset_ff <= 1'b0;
    end else begin
      sys_reset_ff <= expire & eff_re & (~eff_ie | irq_flag_ff);
    end
  end

  // Unlock window counts down four cycles, closed early by its use
  always_ff @(posedge mclk) begin
    if (reset || sys_reset_ff) begin
      win_ff <= '0;
    end else if (unlock_wr) begin
      win_ff <= WIN_W'(UNLOCK_CYCLES);
    end else if (change_wr) begin
      win_ff <= '0;
    end else if (win_open) begin
      win_ff <= win_ff - {{(WIN_W-1){1'b0}}, 1'b1};
    end
  end

  // Reset enable: setting is free, clearing needs window and clear flag
  always_ff @(posedge mclk) begin
    if (reset) begin
      re_ff <= 1'b0;
    end else if (link.ctl_wr && d[BIT_RST_EN]) begin
      re_ff <= 1'b1;
    end else if (change_wr && !rflag_ff) begin
      re_ff <= 1'b0;
    end
  end

  // Time-out code changes only inside the window or on a watchdog reset
  always_ff @(posedge mclk) begin
    if (reset || sys_reset_ff) begin
      tsel_ff <= TSEL_RESET;
    end else if (change_wr) begin
      tsel_ff <= {d[BIT_TSEL_HI], d[BIT_TSEL_LO_TOP:0]};
    end
  end

  // Interrupt enable; vector in combined mode drops to reset-only
  always_ff @(posedge mclk) begin
    if (reset || sys_reset_ff || fuse_ff) begin
      ie_ff <= 1'b0;
    end else if (link.ctl_wr) begin
      ie_ff <= d[BIT_IRQ_EN];
    end else if (link.irq_ack && eff_re) begin
      ie_ff <= 1'b0;
    end
  end

  // Interrupt flag: set wins over write-one or vector clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_flag_ff <= 1'b0;
    end else if (expire && eff_ie) begin
      irq_flag_ff <= 1'b1;
    end else if (sys_reset_ff || link.irq_ack ||
                 (link.ctl_wr && d[BIT_IRQ_FLAG])) begin
      irq_flag_ff <= 1'b0;
    end
  end

  // Reset flag cleared only by power-on or core request; set wins
  always_ff @(posedge mclk) begin
    if (reset) begin
      rflag_ff <= 1'b0;
    end else if (sys_reset_ff) begin
      rflag_ff <= 1'b1;
    end else if (link.rflag_clr) begin
      rflag_ff <= 1'b0;
    end
  end

  assign link.ctl_rdata = {irq_flag_ff, eff_ie, tsel_ff[TSEL_W-1], win_open,
                           eff_re, tsel_ff[TSEL_W-2:0]};
  assign link.rflag = rflag_ff;
  assign link.irq_req = irq_flag_ff & eff_ie;
  assign link.wake = irq_flag_ff & eff_ie;
  assign link.sys_reset = sys_reset_ff;

endmodule : ewdt_device
`default_nettype wire

// ==== ewdt_core.sv ====
// Purpose: Processor-core end of the watchdog link with a software port
// Assumes: Software port on mclk; vector_exec pulses when vector runs
// Notes: Writes are forwarded one cycle later, so write spacing is kept
`timescale 1ns/1ps
`default_nettype none
module ewdt_core
  import ewdt_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [CTL_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [CTL_W-1:0] rdata,
  input wire logic global_irq_en,
  input wire logic vector_exec,
  output logic irq_to_core,
  output logic wake_to_core,
  output logic core_reset,
  ewdt_if.core link
);

  logic ctl_wr_ff;
  logic [CTL_W-1:0] ctl_wdata_ff;
  logic restart_ff;
  logic rflag_clr_ff;
  logic irq_ack_ff;
  logic [CTL_W-1:0] rdata_ff;
  logic [CTL_W-1:0] status;

  // Forward software orders as one-cycle pulses
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctl_wr_ff <= 1'b0;
      ctl_wdata_ff <= '0;
      restart_ff <= 1'b0;
      rflag_clr_ff <= 1'b0;
    end else begin
      ctl_wr_ff <= wr && (addr == REG_CTRL);
      if (wr && (addr == REG_CTRL)) begin
        ctl_wdata_ff <= wdata;
      end
      restart_ff <= wr && (addr == REG_RESTART);
      rflag_clr_ff <= wr && (addr == REG_CAUSE) && !wdata[BIT_WD_RFLAG];
    end
  end

  // Vector acknowledge only for a pending, enabled request
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_ack_ff <= 1'b0;
    end else begin
      irq_ack_ff <= vector_exec & link.irq_req & global_irq_en;
    end
  end

  always_comb begin
    status = '0;
    status[STAT_IRQ] = link.irq_req;
    status[STAT_WAKE] = link.wake;
    status[STAT_WIN] = link.ctl_rdata[BIT_CHG_EN];
  end

  // Read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_ff <= '0;
    end else if (rd) begin
      unique case (addr)
        REG_CTRL: rdata_ff <= link.ctl_rdata;
        REG_CAUSE: rdata_ff <= CTL_W'(link.rflag) << BIT_WD_RFLAG;
        REG_STATUS: rdata_ff <= status;
        default: rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign link.ctl_wr = ctl_wr_ff;
  assign link.ctl_wdata = ctl_wdata_ff;
  assign link.restart = restart_ff;
  assign link.rflag_clr = rflag_clr_ff;
  assign link.irq_ack = irq_ack_ff;
  assign rdata = rdata_ff;
  // Global mask lets software hold off the interrupt during timed writes
  assign irq_to_core = link.irq_req & global_irq_en;
  assign wake_to_core = link.wake;
  assign core_reset = link.sys_reset;

endmodule : ewdt_core
`default_nettype wire

// ==== ewdt_assertions.sv ====
// Purpose: Link checker for the watchdog device and core pair
// Assumes: Every link signal belongs to the mclk domain
// Notes: Sees link signals only; core-side ports are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module ewdt_assertions
  import ewdt_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic ctl_wr,
  input wire logic [CTL_W-1:0] ctl_wdata,
  input wire logic [CTL_W-1:0] ctl_rdata,
  input wire logic restart,
  input wire logic rflag_clr,
  input wire logic rflag,
  input wire logic irq_req,
  input wire logic irq_ack,
  input wire logic wake,
  input wire logic sys_reset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  wire logic win = ctl_rdata[BIT_CHG_EN];
  wire logic [3:0] tsel = {ctl_rdata[BIT_TSEL_HI], ctl_rdata[2:0]};

  a_rst_one_cycle: assert property (sys_reset |=> !sys_reset)
    else $error("reset pulse longer than one cycle");
  a_rflag_after_rst: assert property (sys_reset |=> rflag)
    else $error("reset flag not set after watchdog reset");
  a_flag_forces_re: assert property (rflag |-> ctl_rdata[BIT_RST_EN])
    else $error("reset enable clear while reset flag set");
  a_wake_is_irq: assert property (wake == irq_req)
    else $error("wake differs from interrupt request");
  a_irq_from_flag: assert property (irq_req ==
    (ctl_rdata[BIT_IRQ_FLAG] && ctl_rdata[BIT_IRQ_EN]))
    else $error("interrupt request not flag and enable");
  a_win_opens: assert property (ctl_wr && ctl_wdata[BIT_CHG_EN] &&
    ctl_wdata[BIT_RST_EN] && !sys_reset |=> win)
    else $error("unlock write did not open window");
  a_win_closes: assert property ((win && !ctl_wr) [*4] |=> !win)
    else $error("change window open past four cycles");
  a_tsel_locked: assert property ($changed(tsel) |->
    $past(ctl_wr && !ctl_wdata[BIT_CHG_EN] && win) || $past(sys_reset))
    else $error("time-out select changed outside window");
  a_re_clr_locked: assert property ($fell(ctl_rdata[BIT_RST_EN]) |->
    $past(ctl_wr && win && !rflag) || $past(rflag_clr))
    else $error("reset enable cleared outside window");
  a_ack_clears_ie: assert property (irq_ack &&
    ctl_rdata[BIT_RST_EN] |=> !ctl_rdata[BIT_IRQ_EN])
    else $error("vector did not drop interrupt enable");
  a_flag_needs_ie: assert property ($rose(ctl_rdata[BIT_IRQ_FLAG]) |->
    $past(ctl_rdata[BIT_IRQ_EN]))
    else $error("interrupt flag set with enable off");
endmodule : ewdt_assertions
`default_nettype wire

// ==== ewdt_tb.sv ====
// Purpose: Self-checking bench for the watchdog device and core pair
// Assumes: Oscillator runs at a quarter of mclk to keep time-outs short
// Notes: Fuse is only changed under reset
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin \
  error_cnt++; $display("ERROR %s exp %h got %h", nm, e, s); end end
module testbench;
  import ewdt_pkg::*;
  localparam int DIV = 4;
  localparam int T0 = 2048 * DIV;
  logic mclk, reset, osc_pin, fuse, wr, rd, gie, vec;
  logic [ADDR_W-1:0] addr;
  logic [CTL_W-1:0] wdata, rdata, d;
  logic irq_c, wake_c, rst_c;
  int error_cnt, checks, n;
  ewdt_if lnk();
  ewdt_device u_ewdt_device (.mclk(mclk), .reset(reset),
    .osc_pin(osc_pin), .always_on_fuse(fuse), .link(lnk));
  ewdt_core u_ewdt_core (.mclk(mclk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .global_irq_en(gie),
    .vector_exec(vec), .irq_to_core(irq_c), .wake_to_core(wake_c),
    .core_reset(rst_c), .link(lnk));
  ewdt_assertions u_ewdt_assertions (.mclk(mclk), .reset(reset),
    .ctl_wr(lnk.ctl_wr),
    .ctl_wdata(lnk.ctl_wdata), .ctl_rdata(lnk.ctl_rdata),
    .restart(lnk.restart), .rflag_clr(lnk.rflag_clr), .rflag(lnk.rflag),
    .irq_req(lnk.irq_req), .irq_ack(lnk.irq_ack), .wake(lnk.wake),
    .sys_reset(lnk.sys_reset));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Offset keeps oscillator edges off mclk edges
  initial begin
    osc_pin = 1'b0;
    #3;
    forever #(DIV * 10) osc_pin = ~osc_pin;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    // Read data stands for one cycle only; take it mid-cycle
    @(negedge mclk);
    d = rdata;
    @(posedge mclk);
  endtask : rd_reg
  // Bounded wait on wake (sel 0) or core reset (sel 1)
  task automatic wait_hi(input logic sel);
    n = 0;
    // Mid-cycle sampling so the one-cycle reset pulse is seen settled
    while ((sel ? rst_c : wake_c) !== 1'b1) begin
      @(negedge mclk);
      n++;
      if (n > 5 * T0) begin
        error_cnt++;
        $display("ERROR wait sel %0d exp 1 got 0", sel);
        give_verdict();
      end
    end
  endtask : wait_hi
  task automatic t_unlock();
    rd_reg(REG_CTRL);
    `CHK("ctrl rst", 8'h00, d)
    rd_reg(4'hf);
    `CHK("unmapped", 8'h00, d)
    wr_reg(REG_CTRL, 8'h01);
    rd_reg(REG_CTRL);
    `CHK("no unlock", 8'h00, d)
    wr_reg(REG_CTRL, 8'h18);
    repeat (2) @(posedge mclk);
    wr_reg(REG_CTRL, 8'h01);
    rd_reg(REG_CTRL);
    `CHK("4th cycle", 8'h01, d)
    wr_reg(REG_CTRL, 8'h18);
    repeat (3) @(posedge mclk);
    wr_reg(REG_CTRL, 8'h08);
    rd_reg(REG_CTRL);
    `CHK("5th cycle", 8'h09, d)
    wr_reg(REG_CTRL, 8'h18);
    wr_reg(REG_CTRL, 8'h00);
    rd_reg(REG_CTRL);
    `CHK("re clear", 8'h00, d)
    $display("t_unlock done");
  endtask : t_unlock
  task automatic t_irq();
    gie <= 1'b1;
    wr_reg(REG_CTRL, 8'h40);
    wr_reg(REG_RESTART, 8'h00);
    wait_hi(1'b0);
    `CHK("t code0", 1'b1, (n > T0 - 16) && (n < T0 + 16))
    `CHK("irq core", 1'b1, irq_c)
    rd_reg(REG_CTRL);
    `CHK("flag set", 8'hc0, d)
    rd_reg(REG_STATUS);
    `CHK("status", 8'h03, d)
    gie <= 1'b0;
    @(posedge mclk);
    @(posedge mclk);
    `CHK("irq mask", 1'b0, irq_c)
    wr_reg(REG_CTRL, 8'h18);
    wr_reg(REG_CTRL, 8'hc1);
    rd_reg(REG_CTRL);
    `CHK("flag clr", 8'h41, d)
    wr_reg(REG_RESTART, 8'h00);
    wait_hi(1'b0);
    `CHK("t code1", 1'b1, (n > 2 * T0 - 16) && (n < 2 * T0 + 16))
    `CHK("no reset", 1'b0, rst_c)
    wr_reg(REG_CTRL, 8'h18);
    wr_reg(REG_CTRL, 8'hc8);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_comb();
    gie <= 1'b1;
    wr_reg(REG_RESTART, 8'h00);
    repeat (T0 / 2) @(posedge mclk);
    `CHK("early wake", 1'b0, wake_c)
    wr_reg(REG_RESTART, 8'h00);
    wait_hi(1'b0);
    `CHK("first irq", 1'b1, (n > T0 - 16) && (n < T0 + 16))
    @(posedge mclk);
    vec <= 1'b1;
    @(posedge mclk);
    vec <= 1'b0;
    rd_reg(REG_CTRL);
    `CHK("vec clears", 8'h08, d)
    wait_hi(1'b1);
    `CHK("t reset", 1'b1, (n > T0 - 64) && (n < T0 + 16))
    rd_reg(REG_CAUSE);
    `CHK("cause", 8'h08, d)
    wr_reg(REG_CTRL, 8'h18);
    wr_reg(REG_CTRL, 8'h00);
    rd_reg(REG_CTRL);
    `CHK("re held", 8'h08, d)
    wr_reg(REG_CAUSE, 8'h00);
    wr_reg(REG_CTRL, 8'h18);
    wr_reg(REG_CTRL, 8'h00);
    rd_reg(REG_CTRL);
    `CHK("wd off", 8'h00, d)
    $display("t_comb done");
  endtask : t_comb
  task automatic t_fuse();
    @(posedge mclk);
    reset <= 1'b1;
    fuse <= 1'b1;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    wr_reg(REG_CTRL, 8'h40);
    wr_reg(REG_CTRL, 8'h18);
    wr_reg(REG_CTRL, 8'h40);
    rd_reg(REG_CTRL);
    `CHK("fuse lock", 8'h08, d)
    $display("t_fuse done");
  endtask : t_fuse
  initial begin
    reset = 1'b1;
    fuse = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    gie = 1'b0;
    vec = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    error_cnt = 0;
    checks = 0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    t_unlock();
    t_irq();
    t_comb();
    t_fuse();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
